/* File: rtl/jlx_exec_unit.sv */
`timescale 1ns/1ps
`default_nettype none
// jump and load execution unit: one operation per issue, loads wait for memory
module jlx_exec_unit
  import jlx_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic issue_valid,
  input wire jlx_op_t issue_op,
  input wire logic [63:0] issue_pc,
  input wire logic [25:0] jump_target,
  input wire logic [4:0] source_register_field,
  input wire logic [4:0] target_register_field,
  input wire logic [4:0] dest_register_field,
  input wire logic [15:0] offset,
  input wire logic [1:0] coproc_sel,
  input wire logic [3:0] coproc_usable,
  input wire logic [63:0] source_value,
  input wire logic [63:0] target_value,
  input wire logic cpu_byte_order,
  input wire logic memory_byte_order,
  input wire logic reverse_byte_order,
  input wire logic mem_ack,
  input wire logic [63:0] mem_rdata,
  input wire logic fetch_valid,
  input wire logic [63:0] fetch_pc,
  output logic busy,
  output logic redirect_valid,
  output logic [63:0] redirect_pc,
  output logic mem_req,
  output logic [63:0] mem_vaddr,
  output logic [2:0] mem_paddr_low,
  output logic [2:0] mem_access_size,
  output logic gpr_we,
  output logic [4:0] gpr_waddr,
  output logic [63:0] gpr_wdata,
  output logic cop_we,
  output logic [1:0] cop_num,
  output logic [4:0] cop_reg,
  output logic [63:0] cop_data,
  output logic exc_valid,
  output jlx_exc_t exc_code,
  output logic [63:0] exc_badvaddr
);
  typedef enum logic [1:0] {JLX_IDLE, JLX_SLOT, JLX_MEM} jlx_state_t;

  jlx_state_t state;
  jlx_op_t load_op;
  logic [63:0] jump_dest;
  logic [4:0] load_reg;
  logic [2:0] load_lane;
  logic [63:0] load_old;
  logic [1:0] load_cop;
  logic fwd_valid;
  logic [4:0] fwd_reg;
  logic [63:0] fwd_value;
  logic pending_misalign;
  logic [63:0] pending_pc;

  wire issue_go = clk_en && issue_valid && (state == JLX_IDLE);
  wire [63:0] vaddr;
  wire [2:0] phys_lane;
  wire [2:0] cpu_lane;
  wire [63:0] aligned_result;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire is_abs = (issue_op == JLX_OP_ABS_JUMP) || (issue_op == JLX_OP_ABS_JUMP_LINK);
  wire is_reg = (issue_op == JLX_OP_REG_JUMP) || (issue_op == JLX_OP_REG_JUMP_LINK);
  wire is_link = (issue_op == JLX_OP_ABS_JUMP_LINK) || (issue_op == JLX_OP_REG_JUMP_LINK);
  wire is_load = (issue_op == JLX_OP_LOAD_SBYTE) || (issue_op == JLX_OP_LOAD_UBYTE)
              || (issue_op == JLX_OP_LOAD_DWORD) || (issue_op == JLX_OP_LOAD_COPROC)
              || (issue_op == JLX_OP_LOAD_LEFT);
  wire is_dword = (issue_op == JLX_OP_LOAD_DWORD) || (issue_op == JLX_OP_LOAD_COPROC);
  // delay slot pc is issue_pc plus four; its top bits kept
  wire [63:0] slot_pc = issue_pc + 64'h0000_0000_0000_0004;
  wire [63:0] abs_dest = {slot_pc[63:JLX_PC_KEEP_LSB], jump_target, 2'h0};
  wire [63:0] link_value = issue_pc + JLX_LINK_STEP;
  // link destination: fixed 31 for the absolute form, named register otherwise
  wire [4:0] link_reg = (issue_op == JLX_OP_ABS_JUMP_LINK) ? JLX_LINK_REG
                      : dest_register_field;
  // rs equal rd is deliberately not checked; link is written as usual
  // alignment checked only for doubleword forms; bytes and left loads never
  wire misalign = is_dword && ((vaddr[2:0] & JLX_DWORD_MASK) != 3'h0);
  wire cop_reserved = (issue_op == JLX_OP_LOAD_COPROC)
                   && (coproc_sel == JLX_COP_RESERVED);
  // system coprocessor is undefined: treated as unusable; an odd target register is not checked
  wire cop_unusable = (issue_op == JLX_OP_LOAD_COPROC) && !cop_reserved
                   && (!coproc_usable[coproc_sel] || coproc_sel == JLX_COP_SYSTEM);
  wire load_fault = misalign || cop_reserved || cop_unusable;
  // forward the previous load result for the partial load
  wire [63:0] old_rt = (fwd_valid && fwd_reg == target_register_field) ? fwd_value
                     : target_value;
  // left loads: big-endian memory keeps the lane, little-endian reads the aligned word; byte loads always keep the lane
  wire [2:0] paddr_low = ((issue_op == JLX_OP_LOAD_LEFT) && !memory_byte_order)
                       ? 3'h0 : (is_dword ? 3'h0 : phys_lane);
  wire [2:0] access_size = (issue_op == JLX_OP_LOAD_LEFT) ? cpu_lane
                         : (is_dword ? 3'h7 : 3'h0);
  wire target_fault = pending_misalign && fetch_valid && (fetch_pc == pending_pc);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  jlx_addr_gen u_addr (
    .base_value(source_value),
    .offset(offset),
    .cpu_byte_order(cpu_byte_order),
    .reverse_byte_order(reverse_byte_order),
    .vaddr(vaddr),
    .phys_lane(phys_lane),
    .cpu_lane(cpu_lane)
  );

  jlx_load_align u_align (
    .op(load_op),
    .mem_data(mem_rdata),
    .old_value(load_old),
    .lane(load_lane),
    .result(aligned_result)
  );

  // ---------------------------------------------------------------
  // control state and outputs
  // ---------------------------------------------------------------
  // jumps hold one slot before redirect; loads wait for mem_ack
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      state <= JLX_IDLE;
      load_op <= JLX_OP_NONE;
      jump_dest <= 64'h0;
      load_reg <= 5'h0;
      load_lane <= 3'h0;
      load_old <= 64'h0;
      load_cop <= 2'h0;
      fwd_valid <= 1'b0;
      fwd_reg <= 5'h0;
      fwd_value <= 64'h0;
      pending_misalign <= 1'b0;
      pending_pc <= 64'h0;
      busy <= 1'b0;
      redirect_valid <= 1'b0;
      redirect_pc <= 64'h0;
      mem_req <= 1'b0;
      mem_vaddr <= 64'h0;
      mem_paddr_low <= 3'h0;
      mem_access_size <= 3'h0;
      gpr_we <= 1'b0;
      gpr_waddr <= 5'h0;
      gpr_wdata <= 64'h0;
      cop_we <= 1'b0;
      cop_num <= 2'h0;
      cop_reg <= 5'h0;
      cop_data <= 64'h0;
      exc_valid <= 1'b0;
      exc_code <= JLX_EXC_NONE;
      exc_badvaddr <= 64'h0;
    end
    else if (clk_en)
    begin
      redirect_valid <= 1'b0;
      gpr_we <= 1'b0;
      cop_we <= 1'b0;
      exc_valid <= 1'b0;
      exc_code <= JLX_EXC_NONE;
      if (target_fault)
      begin
        // fault deferred until the target is fetched
        pending_misalign <= 1'b0;
        exc_valid <= 1'b1;
        exc_code <= JLX_EXC_ADDR;
        exc_badvaddr <= pending_pc;
      end
      unique case (state)
        JLX_IDLE:
        begin
          if (issue_go && (is_abs || is_reg))
          begin
            state <= JLX_SLOT;
            busy <= 1'b1;
            jump_dest <= is_abs ? abs_dest : source_value;
            fwd_valid <= 1'b0;
            if (is_reg && (source_value[1:0] & JLX_WORD_MASK) != 2'h0)
            begin
              pending_misalign <= 1'b1;
              pending_pc <= source_value;
            end
            if (is_link)
            begin
              gpr_we <= 1'b1;
              gpr_waddr <= link_reg;
              gpr_wdata <= link_value;
            end
          end
          else if (issue_go && is_load && load_fault)
          begin
            exc_valid <= 1'b1;
            exc_code <= cop_reserved ? JLX_EXC_RESERVED
                      : (misalign ? JLX_EXC_ADDR : JLX_EXC_UNUSABLE);
            exc_badvaddr <= vaddr;
            fwd_valid <= 1'b0;
          end
          else if (issue_go && is_load)
          begin
            state <= JLX_MEM;
            busy <= 1'b1;
            mem_req <= 1'b1;
            mem_vaddr <= vaddr;
            mem_paddr_low <= paddr_low;
            mem_access_size <= access_size;
            load_op <= issue_op;
            load_reg <= target_register_field;
            // register lane follows cpu order; only the memory lane follows reverse order
            load_lane <= cpu_lane;
            load_old <= old_rt;
            load_cop <= coproc_sel;
          end
          else if (issue_go)
          begin
            fwd_valid <= 1'b0;
          end
        end
        JLX_SLOT:
        begin
          // delay slot instruction runs elsewhere this cycle
          state <= JLX_IDLE;
          busy <= 1'b0;
          redirect_valid <= 1'b1;
          redirect_pc <= jump_dest;
        end
        JLX_MEM:
        begin
          if (mem_ack)
          begin
            state <= JLX_IDLE;
            busy <= 1'b0;
            mem_req <= 1'b0;
            if (load_op == JLX_OP_LOAD_COPROC)
            begin
              cop_we <= 1'b1;
              cop_num <= load_cop;
              cop_reg <= load_reg; // odd register passes through unchecked
              cop_data <= mem_rdata;
              fwd_valid <= 1'b0;
            end
            else
            begin
              gpr_we <= 1'b1;
              gpr_waddr <= load_reg;
              gpr_wdata <= aligned_result;
              fwd_valid <= 1'b1;
              fwd_reg <= load_reg;
              fwd_value <= aligned_result;
            end
          end
        end
        default:
        begin
          state <= JLX_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_jump_slot_redirect: assert property (@(posedge core_clk) disable iff (reset)
    (issue_go && is_abs) |=> ##[0:4] (redirect_valid && redirect_pc[1:0] == 2'h0))
    else $error("absolute jump did not redirect");
  a_link_value: assert property (@(posedge core_clk) disable iff (reset)
    (issue_go && issue_op == JLX_OP_ABS_JUMP_LINK) |=>
      (gpr_we && gpr_waddr == 5'h1f && gpr_wdata == $past(issue_pc) + 64'h8))
    else $error("link register write wrong");
  a_reg_jump_dest: assert property (@(posedge core_clk) disable iff (reset)
    (issue_go && issue_op == JLX_OP_REG_JUMP_LINK && clk_en) |=>
      (gpr_waddr == $past(dest_register_field)))
    else $error("register link destination wrong");
  a_no_jump_exc: assert property (@(posedge core_clk) disable iff (reset)
    (issue_go && is_reg && !target_fault) |=> !exc_valid)
    else $error("jump raised exception at issue");
  a_dword_align: assert property (@(posedge core_clk) disable iff (reset)
    (issue_go && issue_op == JLX_OP_LOAD_DWORD && vaddr[2:0] != 3'h0 && !target_fault)
      |=> (exc_valid && exc_code == JLX_EXC_ADDR))
    else $error("misaligned doubleword not faulted");
  a_cop3_reserved: assert property (@(posedge core_clk) disable iff (reset)
    (issue_go && issue_op == JLX_OP_LOAD_COPROC && coproc_sel == 2'h3 && !misalign
      && !target_fault) |=> (exc_code == JLX_EXC_RESERVED))
    else $error("coprocessor 3 not reserved");
  a_left_no_fault: assert property (@(posedge core_clk) disable iff (reset)
    (issue_go && (issue_op == JLX_OP_LOAD_LEFT || issue_op == JLX_OP_LOAD_SBYTE)
      && !target_fault) |=> !exc_valid)
    else $error("byte or left load faulted");
  a_sbyte_ext: assert property (@(posedge core_clk) disable iff (reset)
    (gpr_we && state == JLX_IDLE && $past(state) == JLX_MEM
      && $past(load_op) == JLX_OP_LOAD_SBYTE) |-> (gpr_wdata[63:8] == {56{gpr_wdata[7]}}))
    else $error("signed byte not extended");
endmodule : jlx_exec_unit
`default_nettype wire

/* File: rtl/jlx_pkg.sv */
package jlx_pkg;
  // ---------------------------------------------------------------
  // operation codes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    JLX_OP_NONE,
    JLX_OP_ABS_JUMP,
    JLX_OP_ABS_JUMP_LINK,
    JLX_OP_REG_JUMP,
    JLX_OP_REG_JUMP_LINK,
    JLX_OP_LOAD_SBYTE,
    JLX_OP_LOAD_UBYTE,
    JLX_OP_LOAD_DWORD,
    JLX_OP_LOAD_COPROC,
    JLX_OP_LOAD_LEFT
  } jlx_op_t;

  typedef enum logic [1:0] {
    JLX_EXC_NONE,
    JLX_EXC_ADDR,
    JLX_EXC_RESERVED,
    JLX_EXC_UNUSABLE
  } jlx_exc_t;

  // ---------------------------------------------------------------
  // field layout and constants
  // ---------------------------------------------------------------
  localparam int JLX_TARGET_W = 26;
  localparam int JLX_PC_KEEP_LSB = 28;
  localparam int JLX_OFFSET_W = 16;
  localparam int JLX_LANE_W = 3;
  localparam logic [63:0] JLX_LINK_STEP = 64'h0000_0000_0000_0008;
  localparam logic [4:0] JLX_LINK_REG = 5'h1f;
  localparam logic [1:0] JLX_COP_SYSTEM = 2'h0;
  localparam logic [1:0] JLX_COP_RESERVED = 2'h3;
  localparam logic [2:0] JLX_DWORD_MASK = 3'h7;
  localparam logic [1:0] JLX_WORD_MASK = 2'h3;
endpackage : jlx_pkg

/* File: rtl/jlx_addr_gen.sv */
`timescale 1ns/1ps
`default_nettype none
// effective address and byte lane forming, purely combinational
module jlx_addr_gen
  import jlx_pkg::*;
(
  input wire logic [63:0] base_value,
  input wire logic [15:0] offset,
  input wire logic cpu_byte_order,
  input wire logic reverse_byte_order,
  output logic [63:0] vaddr,
  output logic [2:0] phys_lane,
  output logic [2:0] cpu_lane
);
  // ---------------------------------------------------------------
  // address arithmetic
  // ---------------------------------------------------------------
  // sign-extend the offset and add to base
  assign vaddr = base_value + {{(64 - JLX_OFFSET_W){offset[15]}}, offset};
  // lanes flip with the byte-order settings
  assign phys_lane = vaddr[JLX_LANE_W-1:0] ^ {JLX_LANE_W{reverse_byte_order}};
  assign cpu_lane = vaddr[JLX_LANE_W-1:0] ^ {JLX_LANE_W{cpu_byte_order}};
endmodule : jlx_addr_gen
`default_nettype wire

/* File: rtl/jlx_load_align.sv */
`timescale 1ns/1ps
`default_nettype none
// shapes memory doubleword into the register value for each load kind
module jlx_load_align
  import jlx_pkg::*;
(
  input wire jlx_op_t op,
  input wire logic [63:0] mem_data,
  input wire logic [63:0] old_value,
  input wire logic [2:0] lane,
  output logic [63:0] result
);
  logic [7:0] picked;
  logic [63:0] left_shifted;
  logic [63:0] keep_mask;
  logic [5:0] shamt;

  // ---------------------------------------------------------------
  // byte pick and left merge
  // ---------------------------------------------------------------
  assign picked = mem_data[{lane, 3'h0} +: 8];
  // starting byte lands in the top register byte
  assign shamt = {~lane, 3'h0};
  assign left_shifted = mem_data << shamt;
  // old low bytes survive below the loaded span
  assign keep_mask = ~(64'hffff_ffff_ffff_ffff << shamt);

  // result selection per operation
  always_comb
  begin
    unique case (op)
      JLX_OP_LOAD_SBYTE: result = {{56{picked[7]}}, picked};
      JLX_OP_LOAD_UBYTE: result = {56'h0, picked};
      JLX_OP_LOAD_LEFT: result = left_shifted | (old_value & keep_mask);
      default: result = mem_data;
    endcase
  end
endmodule : jlx_load_align
`default_nettype wire

/* File: bench/jlx_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------
// data memory stand-in
// ----------------------------------------------------------
module jlx_mem_model
#(
  parameter logic [63:0] PATTERN = 64'h5a3c_96e1_0f87_d24b
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic mem_req,
  input wire logic [63:0] mem_vaddr,
  input wire logic [3:0] ack_delay,
  output logic mem_ack,
  output logic [63:0] mem_rdata
);
  logic [3:0] wait_cnt;

  // answers after ack_delay idle cycles with a scramble of the aligned doubleword;
  // between answers the data lines toggle so a late sample never looks right
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      mem_ack <= 1'b0;
      wait_cnt <= 4'h0;
      mem_rdata <= 64'h0;
    end
    else if (mem_req && !mem_ack && wait_cnt >= ack_delay)
    begin
      mem_ack <= 1'b1;
      wait_cnt <= 4'h0;
      mem_rdata <= {mem_vaddr[63:3], 3'h0} ^ PATTERN;
    end
    else
    begin
      mem_ack <= 1'b0;
      wait_cnt <= (mem_req && !mem_ack) ? wait_cnt + 4'h1 : 4'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : jlx_mem_model
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
  import jlx_pkg::*;
;
  localparam logic [63:0] MEM_PAT = 64'h5a3c_96e1_0f87_d24b;
  logic core_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, issue_valid = 1'b0, fetch_valid = 1'b0;
  logic cpu_byte_order = 1'b0, memory_byte_order = 1'b0, reverse_byte_order = 1'b0;
  jlx_op_t issue_op = JLX_OP_NONE;
  logic [63:0] issue_pc = 64'h0, source_value = 64'h0, target_value = 64'h0, fetch_pc = 64'h0;
  logic [25:0] jump_target = 26'h0;
  logic [4:0] source_register_field = 5'h3, target_register_field = 5'h0;
  logic [4:0] dest_register_field = 5'h0;
  logic [15:0] offset = 16'h0;
  logic [1:0] coproc_sel = 2'h0;
  logic [3:0] coproc_usable = 4'h0, ack_delay = 4'h0;
  logic mem_ack, busy, redirect_valid, mem_req, gpr_we, cop_we, exc_valid;
  logic [63:0] mem_rdata, redirect_pc, mem_vaddr, gpr_wdata, cop_data, exc_badvaddr;
  logic [2:0] mem_paddr_low, mem_access_size, exp_sz;
  logic [4:0] gpr_waddr, cop_reg;
  logic [1:0] cop_num;
  jlx_exc_t exc_code;
  logic [68:0] gpr_q[$];
  logic [70:0] cop_q[$];
  logic [65:0] exc_q[$];
  logic [63:0] red_q[$];
  logic [68:0] g;
  logic [70:0] c;
  logic [65:0] e;
  logic [63:0] r, m, tmp, exp_va;
  logic [2:0] exp_pl, sel;
  logic [1:0] chk_mem;
  int num_errors = 0, n_tests = 0, cycles = 0, s;

  jlx_exec_unit i_jlx_exec_unit (.core_clk, .reset, .clk_en, .issue_valid, .issue_op, .issue_pc,
    .jump_target, .source_register_field, .target_register_field, .dest_register_field, .offset,
    .coproc_sel, .coproc_usable, .source_value, .target_value, .cpu_byte_order,
    .memory_byte_order, .reverse_byte_order, .mem_ack, .mem_rdata, .fetch_valid, .fetch_pc, .busy,
    .redirect_valid, .redirect_pc, .mem_req, .mem_vaddr, .mem_paddr_low, .mem_access_size,
    .gpr_we, .gpr_waddr, .gpr_wdata, .cop_we, .cop_num, .cop_reg, .cop_data, .exc_valid, .exc_code,
    .exc_badvaddr);

  jlx_mem_model #(.PATTERN(MEM_PAT)) i_jlx_mem_model (.core_clk, .reset, .mem_req, .mem_vaddr,
    .ack_delay, .mem_ack, .mem_rdata);

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  initial forever #4 core_clk = ~core_clk;

  task automatic tally(input bit ok, input string what);
    n_tests++;
    if (!ok)
    begin
      num_errors++;
      $display("Error at %0t: %s mismatch", $time, what);
    end
  endtask : tally

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  function automatic logic [63:0] mem_of(input logic [63:0] a);
    return {a[63:3], 3'h0} ^ MEM_PAT;
  endfunction : mem_of

  // random base and offset whose sum ends in the wanted low bits
  task automatic set_addr(input logic [2:0] low);
    offset = 16'($urandom);
    exp_va = {$urandom, $urandom};
    exp_va[2:0] = low;
    source_value = exp_va - {{48{offset[15]}}, offset};
  endtask : set_addr

  // merged value of a left load: top bytes from memory, the rest kept
  task automatic left_expect(input logic [63:0] old);
    sel = exp_va[2:0] ^ {3{cpu_byte_order}};
    s = 56 - 8 * int'(sel);
    gpr_q.push_back({target_register_field, (mem_of(exp_va) << s) | (old & ((64'h1 << s) - 1))});
  endtask : left_expect

  // one issue, then wait for busy to drop so the next issue is legal
  task automatic do_op(input jlx_op_t op);
    int n;
    n = 0;
    // access size: dword forms all eight, bytes one, left load up to its cpu lane
    exp_sz = (op == JLX_OP_LOAD_LEFT) ? exp_va[2:0] ^ {3{cpu_byte_order}}
           : ((op == JLX_OP_LOAD_SBYTE || op == JLX_OP_LOAD_UBYTE) ? 3'h0 : 3'h7);
    ack_delay = 4'($urandom_range(5));
    issue_op = op;
    issue_valid = 1'b1;
    @(negedge core_clk);
    issue_valid = 1'b0;
    if (chk_mem != 2'h0)
      tally(mem_req === 1'b1 && mem_vaddr === exp_va && (chk_mem == 2'h1 || mem_paddr_low === exp_pl),
        "memory request");
    if (chk_mem != 2'h0)
      tally(mem_access_size === exp_sz, "access size");
    // at least one idle edge with valid low, even after a faulting load
    do
    begin
      @(negedge core_clk);
      n++;
    end
    while (busy !== 1'b0 && n < 40);
    if (n == 40)
      tally(1'b0, "busy wait");
  endtask : do_op

  // ----------------------------------------------------------
  // result monitor: every output event takes the oldest note
  // ----------------------------------------------------------
  always @(negedge core_clk)
  begin
    if (!reset && gpr_we === 1'b1)
    begin
      g = gpr_q.size() > 0 ? gpr_q.pop_front() : 'x;
      tally({gpr_waddr, gpr_wdata} === g, "register write");
    end
    if (!reset && cop_we === 1'b1)
    begin
      c = cop_q.size() > 0 ? cop_q.pop_front() : 'x;
      tally({cop_num, cop_reg, cop_data} === c, "coprocessor write");
    end
    if (!reset && exc_valid === 1'b1)
    begin
      e = exc_q.size() > 0 ? exc_q.pop_front() : 'x;
      tally(exc_code === e[65:64] && (e[65:64] != 2'h1 || exc_badvaddr === e[63:0]), "exception");
    end
    if (!reset && redirect_valid === 1'b1)
    begin
      r = red_q.size() > 0 ? red_q.pop_front() : 'x;
      tally(redirect_pc === r, "jump target");
    end
  end

  // hang guard, well above the thousand or so cycles the tests need
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      end_sim();
    end
  end

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial
  begin
    void'($urandom(52));
    chk_mem = 2'h0;
    repeat (8) @(negedge core_clk);
    reset = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      issue_pc = {$urandom, $urandom} & 64'hffff_ffff_ffff_fffc;
      jump_target = 26'($urandom);
      tmp = issue_pc + 64'h4;
      red_q.push_back({tmp[63:28], jump_target, 2'h0});
      if (i[0])
        gpr_q.push_back({5'h1f, issue_pc + 64'h8});
      do_op(i[0] ? JLX_OP_ABS_JUMP_LINK : JLX_OP_ABS_JUMP);
    end
    $display("absolute jumps done");
    for (int i = 0; i < 8; i++)
    begin
      issue_pc = {$urandom, $urandom} & 64'hffff_ffff_ffff_fffc;
      source_value = ({$urandom, $urandom} & 64'hffff_ffff_ffff_fffc) | 64'(i[2:1]);
      // i of one names the source register as destination: must not trap
      dest_register_field = 5'(i + 2);
      red_q.push_back(source_value);
      if (i[0])
        gpr_q.push_back({dest_register_field, issue_pc + 64'h8});
      do_op(i[0] ? JLX_OP_REG_JUMP_LINK : JLX_OP_REG_JUMP);
      if (i[2:1] != 0)
      begin
        exc_q.push_back({JLX_EXC_ADDR, source_value});
        fetch_pc = source_value;
        fetch_valid = 1'b1;
        @(negedge core_clk);
        fetch_valid = 1'b0;
        @(negedge core_clk);
      end
    end
    $display("register jumps done");
    for (int i = 0; i < 64; i++)
    begin
      cpu_byte_order = i[3];
      reverse_byte_order = i[4];
      memory_byte_order = 1'($urandom);
      target_register_field = 5'h7;
      set_addr(i[2:0]);
      exp_pl = i[2:0] ^ {3{i[4]}};
      chk_mem = 2'h2;
      m = mem_of(exp_va);
      m = m >> (8 * int'(i[2:0] ^ {3{i[3]}}));
      gpr_q.push_back({5'h7, i[5] ? {{56{m[7]}}, m[7:0]} : {56'h0, m[7:0]}});
      do_op(i[5] ? JLX_OP_LOAD_SBYTE : JLX_OP_LOAD_UBYTE);
    end
    $display("byte loads done");
    for (int i = 0; i < 16; i++)
    begin
      target_register_field = 5'h5;
      set_addr(i[2:0] & {3{i[3]}});
      chk_mem = {1'b0, exp_va[2:0] == 3'h0};
      if (chk_mem == 2'h0)
        exc_q.push_back({JLX_EXC_ADDR, exp_va});
      else
        gpr_q.push_back({5'h5, mem_of(exp_va)});
      do_op(JLX_OP_LOAD_DWORD);
    end
    $display("doubleword loads done");
    for (int i = 0; i < 32; i++)
    begin
      coproc_sel = i[1:0];
      coproc_usable = i[2] ? 4'h1 << i[1:0] : ~(4'h1 << i[1:0]);
      target_register_field = 5'h4;
      set_addr({i[4:3], 1'b0});
      chk_mem = 2'h0;
      if (i[1:0] == 3)
        exc_q.push_back({JLX_EXC_RESERVED, exp_va});
      else if (i[4:3] != 0)
        exc_q.push_back({JLX_EXC_ADDR, exp_va});
      else if (i[1:0] == 0 || !i[2])
        exc_q.push_back({JLX_EXC_UNUSABLE, exp_va});
      else
      begin
        chk_mem = 2'h1;
        cop_q.push_back({i[1:0], 5'h4, mem_of(exp_va)});
      end
      do_op(JLX_OP_LOAD_COPROC);
    end
    $display("coprocessor loads done");
    for (int i = 0; i < 32; i++)
    begin
      cpu_byte_order = i[3];
      memory_byte_order = i[4];
      reverse_byte_order = 1'($urandom);
      target_register_field = 5'(8 + i[0]);
      target_value = {$urandom, $urandom};
      set_addr(i[2:0]);
      exp_pl = i[4] ? i[2:0] ^ {3{reverse_byte_order}} : 3'h0;
      chk_mem = 2'h2;
      left_expect(target_value);
      do_op(JLX_OP_LOAD_LEFT);
    end
    $display("left loads done");
    for (int i = 0; i < 4; i++)
    begin
      target_register_field = 5'h6;
      set_addr(3'h0);
      chk_mem = 2'h1;
      m = mem_of(exp_va);
      gpr_q.push_back({5'h6, m});
      do_op(JLX_OP_LOAD_DWORD);
      target_value = ~m;
      set_addr(3'(i * 3));
      left_expect(m);
      do_op(JLX_OP_LOAD_LEFT);
    end
    $display("load forwarding done");
    repeat (4) @(negedge core_clk);
    tally(gpr_q.size() + cop_q.size() + exc_q.size() + red_q.size() == 0, "missing result");
    end_sim();
  end
endmodule : tb
`default_nettype wire
